// [verilog/rcs_pkg.sv]
// Shared constants for the redundant reference clock switch
package rcs_pkg;
  localparam int          BANK_W          = 6;
  localparam int          ACC_W           = 24;
  localparam logic [23:0] INC_INIT        = 24'h020000;
  localparam logic [23:0] INC_STEP        = 24'h000100;
  localparam logic [7:0]  FAIL_WINDOW_RST = 8'h08;
  localparam logic [3:0]  LOCK_COUNT      = 4'h8;
  localparam logic [2:0]  FSEL_X8         = 3'h0;
  localparam logic [2:0]  FSEL_X4         = 3'h1;
  localparam logic [2:0]  FSEL_X3         = 3'h2;
  localparam logic [2:0]  FSEL_X2         = 3'h3;
  localparam logic [3:0]  RATIO_X8        = 4'h8;
  localparam logic [3:0]  RATIO_X4        = 4'h4;
  localparam logic [3:0]  RATIO_X3        = 4'h3;
  localparam logic [3:0]  RATIO_X2        = 4'h2;
  localparam logic [3:0]  RATIO_X1        = 4'h1;
  localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
  localparam logic [3:0]  LOOP_OFFSET     = 4'h8;
  localparam int          CTRL_CLR_BIT    = 8;
  localparam int          STAT_FAIL0_BIT  = 0;
  localparam int          STAT_FAIL1_BIT  = 1;
  localparam int          STAT_IND_BIT    = 2;
  localparam int          STAT_LOCK_BIT   = 3;
  localparam int          STAT_BYP_BIT    = 4;
  localparam int          STAT_OD_BIT     = 5;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic {RCS_SEL_PRIMARY, RCS_SEL_SECONDARY} rcs_sel_t;
endpackage : rcs_pkg

// [verilog/rcs_ref_monitor.sv]
// Activity monitor for one reference clock input
`timescale 1ns/1ns
`default_nettype none
module rcs_ref_monitor
  import rcs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       refIn,
  input  wire logic       fbRise,
  input  wire logic [7:0] window,
  output logic            refLevel,
  output logic            refRise,
  output logic            refAlive,
  output logic            failStrobe
);
  logic       refMeta;
  logic       refPrev;
  logic [7:0] fbCount;
  wire        reachWindow = fbRise && !refRise && (fbCount == window - 8'h01);

  assign refRise  = refLevel && !refPrev;
  assign refAlive = (fbCount != window);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refMeta   <= 1'b0;
      refLevel  <= 1'b0;
      refPrev   <= 1'b0;
      fbCount   <= 8'h00;
      failStrobe <= 1'b0;
    end else if (ce) begin
      refMeta   <= refIn;
      refLevel  <= refMeta;
      refPrev   <= refLevel;
      failStrobe <= reachWindow;
      if (refRise || clear) begin
        fbCount <= 8'h00;
      end else if (fbRise && refAlive) begin
        fbCount <= fbCount + 8'h01;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_fail_window;
    ce && reachWindow && !clear |=> failStrobe && !refAlive;
  endproperty
  a_fail_window: assert property (p_fail_window) else $error("Missed reference failure");
endmodule : rcs_ref_monitor
`default_nettype wire

// [verilog/rcs_clock_switch.sv]
// Redundant reference clock switch and generator control
//
// Overview of operation
// - Bank A runs at selected reference times one, two, three, four or eight.
// - All six bank A outputs carry the same multiplied clock.
// - Bank B runs at bank A frequency or half of it.
// - Banks align at common rising edges and follow the reference via feedback.
// - Both references are watched while output disable is off, failure reported per input.
// - Automatic mode fails over to the other input and slews gradually.
// - Inputs are symmetric; a restored input may be selected again.
// - Manual mode switches reference only by user selection.
// - Bypass disables automatic failover.
// - Bypass passes the reference clock statically to the outputs.
// - Output disable turns bank output drivers off.
// - Output disable also resets the loop and output dividers.
// - One active-low alarm output per reference input.
// - Indicator output shows the currently selected reference.
// - Alarm reset clears both alarms and restores the reference selection.
// - Reference select picks the primary reference input.
// - Switch mode picks automatic failover or manual selection.
// - Four ratio select bits set multiplication and bank B divider.
// - Bypass replaces oscillator with reference and forces manual mode.
// - Failure overrides reference select only in automatic mode without bypass.
// - Alarm reset is an active-low one-shot: alarms high, indicator equals select.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module rcs_clock_switch
  import rcs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              primaryRefIn,
  input  wire logic              secondaryRefIn,
  input  wire logic              feedbackIn,
  input  wire logic              refSelect,
  input  wire logic              switchModeSelect,
  input  wire logic              alarmResetN,
  input  wire logic              bypassSelect,
  input  wire logic [3:0]        ratioSelect,
  input  wire logic              outputDisableReset,
  output logic      [BANK_W-1:0] bankAOutputs,
  output logic      [BANK_W-1:0] bankBOutputs,
  output logic                   bankOutputEnable,
  output logic                   feedbackClockOut,
  output logic                   primaryFailFlagN,
  output logic                   secondaryFailFlagN,
  output logic                   activeRefIndicator,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // Pin synchronisers: stage one feeds only stage two
  logic [9:0]       pinMeta;
  logic [9:0]       pinSync;
  logic             fbPrev;
  logic             alarmRstPrev;
  // Loop state
  logic [ACC_W-1:0] phaseAcc;
  logic [23:0]      increment;
  logic             vcoPrev;
  logic [3:0]       halfCnt;
  logic [1:0]       fbEdges;
  logic [3:0]       lockCnt;
  logic             locked;
  rcs_sel_t         activeRef;
  logic             selLoaded;
  // Registers
  logic [7:0]       failWindow;
  logic             softAlarmClr;
  logic [3:0]       awAddr;
  logic             awHeld;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             wHeld;

  wire       fbSync      = pinSync[0];
  wire       refSelSync  = pinSync[1];
  wire       autoSync    = pinSync[2];
  wire       alarmRstN   = pinSync[3];
  wire       bypassSync  = pinSync[4];
  wire [3:0] ratioSync   = pinSync[8:5];
  wire       odSync      = pinSync[9];

  wire       fbRise      = fbSync && !fbPrev;
  wire       alarmShot   = (!alarmRstN && alarmRstPrev) || softAlarmClr;
  wire       autoActive  = autoSync && !bypassSync;

  logic      ref0Level;
  logic      ref0Rise;
  logic      ref0Alive;
  logic      fail0;
  logic      ref1Level;
  logic      ref1Rise;
  logic      ref1Alive;
  logic      fail1;

  rcs_ref_monitor u_mon0 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .clear     (odSync),
    .refIn     (primaryRefIn),
    .fbRise    (fbRise),
    .window    (failWindow),
    .refLevel  (ref0Level),
    .refRise   (ref0Rise),
    .refAlive  (ref0Alive),
    .failStrobe (fail0)
  );

  rcs_ref_monitor u_mon1 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .clear     (odSync),
    .refIn     (secondaryRefIn),
    .fbRise    (fbRise),
    .window    (failWindow),
    .refLevel  (ref1Level),
    .refRise   (ref1Rise),
    .refAlive  (ref1Alive),
    .failStrobe (fail1)
  );

  // Ratio decode, bit 0 halves bank B
  logic [3:0] ratio;
  always_comb begin
    case (ratioSync[3:1])
      FSEL_X8: ratio = RATIO_X8;
      FSEL_X4: ratio = RATIO_X4;
      FSEL_X3: ratio = RATIO_X3;
      FSEL_X2: ratio = RATIO_X2;
      default: ratio = RATIO_X1;
    endcase
  end
  wire bankBHalf = ratioSync[0];

  wire selIsSec   = (activeRef == RCS_SEL_SECONDARY);
  wire selLevel   = selIsSec ? ref1Level : ref0Level;
  wire selRise    = selIsSec ? ref1Rise : ref0Rise;
  wire selFail    = selIsSec ? fail1 : fail0;
  wire otherAlive = selIsSec ? ref0Alive : ref1Alive;

  // Failover state machine
  rcs_sel_t next_activeRef;
  always_comb begin
    next_activeRef = activeRef;
    if (!autoActive || alarmShot || !selLoaded) begin
      next_activeRef = refSelSync ? RCS_SEL_SECONDARY : RCS_SEL_PRIMARY;
    end else if (selFail && otherAlive) begin
      case (activeRef)
        RCS_SEL_PRIMARY:   next_activeRef = RCS_SEL_SECONDARY;
        RCS_SEL_SECONDARY: next_activeRef = RCS_SEL_PRIMARY;
        default:           next_activeRef = RCS_SEL_PRIMARY;
      endcase
    end
  end

  // Numerically controlled oscillator with bang-bang phase steering
  wire [ACC_W-1:0] next_phaseAcc = phaseAcc + increment;
  wire             vcoLevel      = next_phaseAcc[ACC_W-1];
  wire             vcoEdge       = vcoLevel != vcoPrev;
  wire [4:0]       halfTop       = {ratio, 1'b0} - 5'h01;
  wire [3:0]       next_halfCnt  = !vcoEdge ? halfCnt :
                                   ({1'b0, halfCnt} == halfTop) ? 4'h0 : halfCnt + 4'h1;
  wire             fbDivLevel    = next_halfCnt < ratio;
  wire             incUp         = selRise && !fbSync && (increment <= ~INC_STEP);
  wire             incDown       = selRise && fbSync && (increment > INC_STEP);
  wire             srcA          = bypassSync ? selLevel : vcoLevel;
  wire             srcARise      = srcA && !bankAOutputs[0];
  logic            bankBLevel;
  wire             next_bankB    = (bankBHalf && !bypassSync) ?
                                   (srcARise ? !bankBLevel : bankBLevel) : srcA;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta      <= 10'h208;
      pinSync      <= 10'h208;
      fbPrev       <= 1'b0;
      alarmRstPrev <= 1'b1;
    end else if (ce) begin
      pinMeta      <= {outputDisableReset, ratioSelect, bypassSelect, alarmResetN,
                       switchModeSelect, refSelect, feedbackIn};
      pinSync      <= pinMeta;
      fbPrev       <= fbSync;
      alarmRstPrev <= alarmRstN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || (ce && odSync)) begin
      phaseAcc <= {ACC_W{1'b0}};
      increment <= INC_INIT;
      vcoPrev <= 1'b0;
      halfCnt <= 4'h0;
    end else if (ce) begin
      phaseAcc <= next_phaseAcc;
      vcoPrev <= vcoLevel;
      halfCnt <= next_halfCnt;
      if (incUp) begin
        increment <= increment + INC_STEP;
      end else if (incDown) begin
        increment <= increment - INC_STEP;
      end
    end
  end

  // Lock: one feedback edge per reference period for several periods
  always_ff @(posedge sys_clk) begin
    if (rst || (ce && odSync)) begin
      fbEdges <= 2'h0;
      lockCnt <= 4'h0;
      locked  <= 1'b0;
    end else if (ce) begin
      if (selRise) begin
        fbEdges <= 2'h0;
        lockCnt <= (fbEdges == 2'h1) ? ((lockCnt == LOCK_COUNT) ? lockCnt : lockCnt + 4'h1)
                                     : 4'h0;
        locked  <= (fbEdges == 2'h1) && (lockCnt == LOCK_COUNT);
      end else if (fbRise && fbEdges != 2'h3) begin
        fbEdges <= fbEdges + 2'h1;
      end
    end
  end

  // Selection, alarms and indicator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      activeRef          <= RCS_SEL_PRIMARY;
      selLoaded          <= 1'b0;
      primaryFailFlagN   <= 1'b1;
      secondaryFailFlagN <= 1'b1;
      activeRefIndicator <= 1'b0;
    end else if (ce) begin
      activeRef          <= next_activeRef;
      selLoaded          <= 1'b1;
      activeRefIndicator <= (next_activeRef == RCS_SEL_SECONDARY);
      if (fail0) begin
        primaryFailFlagN <= 1'b0;
      end else if (alarmShot) begin
        primaryFailFlagN <= 1'b1;
      end
      if (fail1) begin
        secondaryFailFlagN <= 1'b0;
      end else if (alarmShot) begin
        secondaryFailFlagN <= 1'b1;
      end
    end
  end

  // Output stage, one flop per pin
  genvar gi;
  generate
    for (gi = 0; gi < BANK_W; gi = gi + 1) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (rst || (ce && odSync)) begin
          bankAOutputs[gi] <= 1'b0;
          bankBOutputs[gi] <= 1'b0;
        end else if (ce) begin
          bankAOutputs[gi] <= srcA;
          bankBOutputs[gi] <= next_bankB;
        end
      end
    end
  endgenerate
  assign bankBLevel = bankBOutputs[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bankOutputEnable <= 1'b0;
      feedbackClockOut <= 1'b0;
    end else if (ce) begin
      bankOutputEnable <= !odSync;
      feedbackClockOut <= bypassSync ? selLevel : (fbDivLevel && !odSync);
    end
  end

  // Register bus slave
  wire        awTake  = s_axi_awvalid && s_axi_awready;
  wire        wTake   = s_axi_wvalid && s_axi_wready;
  wire        haveAw  = awHeld || awTake;
  wire        haveW   = wHeld || wTake;
  wire [3:0]  wrAddr  = awTake ? s_axi_awaddr : awAddr;
  wire [31:0] wrData  = wTake ? s_axi_wdata : wData;
  wire [3:0]  wrStrb  = wTake ? s_axi_wstrb : wStrb;
  wire        doWrite = haveAw && haveW && !s_axi_bvalid;
  wire        wrCtrl  = doWrite && (wrAddr == CTRL_OFFSET);
  wire        wrOk    = wrCtrl || (wrAddr == STATUS_OFFSET) || (wrAddr == LOOP_OFFSET);
  wire        arTake  = s_axi_arvalid && s_axi_arready;
  logic [31:0] rdData;
  logic        rdOk;
  always_comb begin
    rdData = 32'h00000000;
    rdOk   = 1'b1;
    if (s_axi_araddr == CTRL_OFFSET) begin
      rdData[7:0] = failWindow;
    end else if (s_axi_araddr == STATUS_OFFSET) begin
      rdData[STAT_FAIL0_BIT] = primaryFailFlagN;
      rdData[STAT_FAIL1_BIT] = secondaryFailFlagN;
      rdData[STAT_IND_BIT]   = activeRefIndicator;
      rdData[STAT_LOCK_BIT]  = locked;
      rdData[STAT_BYP_BIT]   = bypassSync;
      rdData[STAT_OD_BIT]    = odSync;
    end else if (s_axi_araddr == LOOP_OFFSET) begin
      rdData[23:0] = increment;
    end else begin
      rdOk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      failWindow    <= FAIL_WINDOW_RST;
      softAlarmClr  <= 1'b0;
    end else if (ce) begin
      softAlarmClr <= wrCtrl && wrStrb[1] && wrData[CTRL_CLR_BIT];
      if (awTake) begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        if (wrCtrl && wrStrb[0] && wrData[7:0] != 8'h00) begin
          failWindow <= wrData[7:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdData;
        s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_bank_a_equal;
    bankAOutputs == {BANK_W{bankAOutputs[0]}} && bankBOutputs == {BANK_W{bankBOutputs[0]}};
  endproperty
  a_bank_a_equal: assert property (p_bank_a_equal) else $error("Bank outputs differ");

  property p_bank_b_half;
    $rose(bankBOutputs[0]) && $past(bankBHalf && !bypassSync && !odSync && ce)
      |-> $rose(bankAOutputs[0]);
  endproperty
  a_bank_b_half: assert property (p_bank_b_half) else $error("Bank B rise off bank A");

  property p_disable;
    ce && odSync |=> !bankOutputEnable && bankAOutputs == '0 && halfCnt == 4'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("Disable did not reset outputs");

  property p_alarm_set;
    ce && fail0 |=> !primaryFailFlagN;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("Primary alarm not raised");

  property p_alarm_clear;
    ce && alarmShot && !fail0 && !fail1
      |=> primaryFailFlagN && secondaryFailFlagN && activeRefIndicator == $past(refSelSync);
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("Alarm reset incomplete");

  property p_manual;
    ce && !autoActive |=> activeRefIndicator == $past(refSelSync);
  endproperty
  a_manual: assert property (p_manual) else $error("Manual selection not followed");

  property p_failover;
    ce && autoActive && selLoaded && !alarmShot && selFail && otherAlive
      |=> activeRefIndicator != $past(activeRefIndicator);
  endproperty
  a_failover: assert property (p_failover) else $error("Failover did not occur");

  property p_slew;
    ce && !odSync |=> increment == $past(increment) || increment == $past(increment) + INC_STEP
                      || increment == $past(increment) - INC_STEP;
  endproperty
  a_slew: assert property (p_slew) else $error("Loop step too large");

  property p_bypass;
    ce && bypassSync && !odSync |=> bankAOutputs[0] == $past(selLevel)
                                    && feedbackClockOut == $past(selLevel);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass not passing reference");

  property p_hold_flag;
    ce && !primaryFailFlagN && !alarmShot |=> !primaryFailFlagN;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("Alarm dropped without reset");
endmodule : rcs_clock_switch
`default_nettype wire

// [tb/rcs_ref_model.sv]
// Two stoppable reference clock sources
`timescale 1ns/1ns
`default_nettype none
module rcs_ref_model (
  input  wire logic sys_clk,
  input  wire logic runP,
  input  wire logic runS,
  output logic      refP,
  output logic      refS
);
  logic [5:0] phase = 6'h00;
  // Half period 64 cycles, matching the loop's reset rate at ratio one
  always @(posedge sys_clk) begin
    phase <= phase + 6'h01;
    if (phase == 6'h3f)
      refP <= runP & (refP !== 1'b1);
    if (phase == 6'h1f)
      refS <= runS & (refS !== 1'b1);
  end
endmodule : rcs_ref_model
`default_nettype wire

// [tb/redundant_clock_switch_generator_test.sv]
// Self-checking bench for the clock switch
`timescale 1ns/1ns
`default_nettype none
module redundant_clock_switch_generator_test
  import rcs_pkg::*;
;
  logic sys_clk, rst, ce, primaryRefIn, secondaryRefIn, feedbackIn, refSelect;
  logic switchModeSelect, alarmResetN, bypassSelect, outputDisableReset, runP, runS;
  logic [3:0] ratioSelect, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [5:0] bankAOutputs, bankBOutputs;
  logic bankOutputEnable, feedbackClockOut, primaryFailFlagN, secondaryFailFlagN;
  logic activeRefIndicator, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0;
  int testsRun = 0;
  int n;
  assign feedbackIn = feedbackClockOut;
  rcs_clock_switch uut (.*);
  rcs_ref_model src (.sys_clk(sys_clk), .runP(runP), .runS(runS),
                     .refP(primaryRefIn), .refS(secondaryRefIn));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 || !s_axi_bready);
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 || !s_axi_rready);
    rd = s_axi_rdata;
  endtask : rdr
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(50 * 30000);
    mismatches++;
    give_verdict();
  end
  initial begin
    {rst, ce, outputDisableReset, runP, runS} = 5'h1f;
    {refSelect, switchModeSelect, alarmResetN, bypassSelect} = 4'h6;
    {ratioSelect, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 16'h900f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (300) @(posedge sys_clk);
    chk("enable in reset", 32'h0, bankOutputEnable);
    outputDisableReset <= 1'b0;
    repeat (600) @(posedge sys_clk);
    chk("enable", 32'h1, bankOutputEnable);
    chk("bank a equal", {6{bankAOutputs[0]}}, bankAOutputs);
    chk("bank b equal", {6{bankBOutputs[0]}}, bankBOutputs);
    rdr(CTRL_OFFSET);
    chk("window", 32'(FAIL_WINDOW_RST), rd);
    rdr(STATUS_OFFSET);
    for (n = 0; n < 40 && rd[STAT_LOCK_BIT] !== 1'b1; n++) begin
      repeat (64) @(posedge sys_clk);
      rdr(STATUS_OFFSET);
    end
    chk("status", 32'h0b, rd & 32'h3f);
    rdr(4'hc);
    chk("unmapped resp", 32'(RESP_SLVERR), s_axi_rresp);
    chk("unmapped data", 32'h0, rd);
    runP <= 1'b0;
    for (n = 0; n < 2000 && primaryFailFlagN !== 1'b0; n++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk("fail0", 32'h0, primaryFailFlagN);
    chk("fail1", 32'h1, secondaryFailFlagN);
    chk("failover", 32'h1, activeRefIndicator);
    runP <= 1'b1;
    repeat (300) @(posedge sys_clk);
    chk("sticky", 32'h0, primaryFailFlagN);
    alarmResetN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    alarmResetN <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("clear0", 32'h1, primaryFailFlagN);
    chk("clear ind", 32'h0, activeRefIndicator);
    switchModeSelect <= 1'b0;
    refSelect <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("manual sel", 32'h1, activeRefIndicator);
    runS <= 1'b0;
    for (n = 0; n < 2000 && secondaryFailFlagN !== 1'b0; n++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk("fail1 manual", 32'h0, secondaryFailFlagN);
    chk("manual hold", 32'h1, activeRefIndicator);
    runS <= 1'b1;
    wr(CTRL_OFFSET, 32'h108);
    chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    repeat (4) @(posedge sys_clk);
    chk("reg clear", 32'h1, secondaryFailFlagN);
    bypassSelect <= 1'b1;
    switchModeSelect <= 1'b1;
    refSelect <= 1'b0;
    runP <= 1'b0;
    repeat (400) @(posedge sys_clk);
    rdr(STATUS_OFFSET);
    chk("bypass bit", 32'h1, 32'(rd[STAT_BYP_BIT]));
    chk("bypass no switch", 32'h0, activeRefIndicator);
    give_verdict();
  end
endmodule : redundant_clock_switch_generator_test
`default_nettype wire
